//--- rtl/pot_cmd_decoder.sv
/*
 Command decoder of a single-wiper digital potentiometer: frames the
 serial stream into identification, instruction and data bytes, runs the
 wiper and setting register commands, the increment/decrement mode and
 the timed nonvolatile save.
 Assumes pins arrive asynchronously; the serial clock idles between
 frames and runs no faster than about a third of core_clk.
*/
`default_nettype none

module pot_cmd_decoder #(
   parameter logic [3:0] DEVICE_TYPE_ID  = 4'hA, // Arbitrary value
   parameter int         NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES
) (
   // Core clock and reset
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   // Serial link
   input  wire logic       sck_clk,
   input  wire logic       cs_n,
   input  wire logic       si,
   output var  logic       so_out,
   output var  logic       so_oe,
   // Straps
   input  wire logic       address_select_pin,
   input  wire logic       wp_n,
   // Potentiometer state
   output var  logic [5:0] wiper_position,
   output var  logic       write_busy_flag
);

   localparam logic [7:0] SETTLE_LOAD =
      8'(pot_pkg::WIPER_SETTLE_CYCLES);
   localparam logic [23:0] NV_LOAD = 24'(NV_WRITE_CYCLES);
   localparam int SETTLE_C = pot_pkg::WIPER_SETTLE_CYCLES;

   generate
      if (NV_WRITE_CYCLES < 1 || NV_WRITE_CYCLES > 24'hFFFFFF)
         $error("NV_WRITE_CYCLES out of range");
      if (pot_pkg::WIPER_SETTLE_CYCLES > 255)
         $error("Settle delay too long for its counter");
   endgenerate

   pot_pkg::cmd_state_t state_reg;
   pot_pkg::cmd_state_t state_next;

   logic [5:0]  wiper_reg;
   logic [5:0]  wiper_next;
   logic [5:0]  set_reg [pot_pkg::SET_COUNT];
   logic [7:0]  shreg_reg;
   logic [4:0]  cnt_reg;
   logic [3:0]  op_reg;
   logic [1:0]  ptr_reg;
   logic [7:0]  rd_byte_reg;
   logic        rd_en_reg;
   logic        pend_reg;
   logic [1:0]  pend_ptr_reg;
   logic [5:0]  pend_data_reg;
   logic        busy_reg;
   logic [23:0] busy_cnt_reg;
   logic [7:0]  settle_cnt_reg;
   logic [5:0]  settle_val_reg;
   logic        cs_prev_reg;
   logic        tgl_d1_reg;
   logic        tgl_d2_reg;

   logic        cs_n_s;
   logic        wp_n_s;
   logic        addr_s;
   logic        tgl_s;
   logic        link_bit;
   logic        link_bit_raw;
   logic        link_tgl;

   level_sync #(
      .W    (3),
      .INIT (3'h7)
   ) u_pin_sync (
      .clk (core_clk),
      .rst (sys_rst),
      .d   ({cs_n, wp_n, address_select_pin}),
      .q   ({cs_n_s, wp_n_s, addr_s})
   );

   // The bit rides the toggle's chain; read one toggle stage later it
   // was taken long after the serial edge and before the next one
   level_sync #(
      .W    (2),
      .INIT (2'h0)
   ) u_tgl_sync (
      .clk (core_clk),
      .rst (sys_rst),
      .d   ({link_tgl, link_bit_raw}),
      .q   ({tgl_s, link_bit})
   );

   pot_link u_link (
      .sck_clk  (sck_clk),
      .cs_n     (cs_n),
      .si       (si),
      .so_out   (so_out),
      .so_oe    (so_oe),
      .rd_byte  (rd_byte_reg),
      .rd_en    (rd_en_reg),
      .bit_hold (link_bit_raw),
      .bit_tgl  (link_tgl)
   );

   // Decode of the incoming bit stream
   wire       bit_ev;
   wire       cs_rise;
   wire [7:0] shreg_next;
   wire [4:0] cnt_next;
   wire [3:0] op_in;
   wire [1:0] ptr_in;
   wire       id_match;
   wire       ptr_free_op;
   wire       ptr_any_op;
   wire       op_valid;
   wire       read_op;
   wire [7:0] rd_value;
   wire       at_id;
   wire       at_ptr;
   wire       at_instr;
   wire       at_data;
   wire       step;
   wire       nv_start;
   wire       settle_done;

   // The extra toggle stage keeps the deselect clear of the toggle from
   // being seen as a bit before chip select is seen high
   assign bit_ev      = (tgl_d1_reg != tgl_d2_reg) && !cs_n_s;
   assign cs_rise     = cs_n_s && !cs_prev_reg;
   assign shreg_next  = {shreg_reg[6:0], link_bit};
   assign cnt_next    = (cnt_reg == pot_pkg::BITS_SAT) ? cnt_reg
                        : cnt_reg + 5'h01;
   assign op_in       = shreg_next[5:2];
   assign ptr_in      = shreg_next[1:0];
   assign id_match    = (shreg_next[7:4] == DEVICE_TYPE_ID)
                        && (shreg_next[0] == addr_s);
   assign ptr_free_op = (op_in == pot_pkg::OP_RD_WIPER)
                        || (op_in == pot_pkg::OP_WR_WIPER)
                        || (op_in == pot_pkg::OP_INCDEC)
                        || (op_in == pot_pkg::OP_STATUS);
   assign ptr_any_op  = (op_in == pot_pkg::OP_RD_SET)
                        || (op_in == pot_pkg::OP_WR_SET)
                        || (op_in == pot_pkg::OP_TO_WIPER)
                        || (op_in == pot_pkg::OP_TO_SET);
   assign op_valid    = ptr_any_op || (ptr_free_op && ptr_in == 2'h0);
   assign read_op     = (op_in == pot_pkg::OP_RD_WIPER)
                        || (op_in == pot_pkg::OP_RD_SET)
                        || (op_in == pot_pkg::OP_STATUS);
   assign rd_value    = (op_in == pot_pkg::OP_STATUS)
                        ? {7'h00, busy_reg}
                        : (op_in == pot_pkg::OP_RD_SET)
                        ? {2'h0, set_reg[ptr_in]}
                        : {2'h0, wiper_reg};
   assign at_id       = bit_ev && state_reg == pot_pkg::ST_ID
                        && cnt_next == pot_pkg::BITS_ID;
   assign at_ptr      = bit_ev && state_reg == pot_pkg::ST_INSTR
                        && cnt_next == pot_pkg::BITS_PTR;
   assign at_instr    = bit_ev && state_reg == pot_pkg::ST_INSTR
                        && cnt_next == pot_pkg::BITS_INSTR;
   assign at_data     = bit_ev && state_reg == pot_pkg::ST_DATA
                        && cnt_next == pot_pkg::BITS_DATA;
   assign step        = bit_ev && state_reg == pot_pkg::ST_INCDEC;
   assign nv_start    = cs_rise && pend_reg && !busy_reg
                        && wp_n_s;
   assign settle_done = settle_cnt_reg == 8'h01;

   always_comb
   begin
      state_next = state_reg;
      if (cs_n_s)
         state_next = pot_pkg::ST_IDLE;
      else
         case (state_reg)
            pot_pkg::ST_IDLE:
               state_next = pot_pkg::ST_ID;
            pot_pkg::ST_ID:
               if (at_id)
                  state_next = id_match ? pot_pkg::ST_INSTR
                               : pot_pkg::ST_IGNORE;
            pot_pkg::ST_INSTR:
               if (at_ptr && !op_valid)
                  state_next = pot_pkg::ST_IGNORE;
               else if (at_instr)
                  case (op_reg)
                     pot_pkg::OP_INCDEC:
                        state_next = pot_pkg::ST_INCDEC;
                     pot_pkg::OP_TO_WIPER,
                     pot_pkg::OP_TO_SET:
                        state_next = pot_pkg::ST_IGNORE;
                     default:
                        state_next = pot_pkg::ST_DATA;
                  endcase
            pot_pkg::ST_DATA:
               if (at_data)
                  state_next = pot_pkg::ST_IGNORE;
            pot_pkg::ST_INCDEC:
               state_next = pot_pkg::ST_INCDEC;
            pot_pkg::ST_IGNORE:
               state_next = pot_pkg::ST_IGNORE;
            default:
               state_next = pot_pkg::ST_IDLE;
         endcase
   end

   always_comb
   begin
      wiper_next = wiper_reg;
      if (at_data && op_reg == pot_pkg::OP_WR_WIPER)
         wiper_next = shreg_next[5:0];
      else if (step && link_bit && wiper_reg != pot_pkg::WIPER_MAX)
         wiper_next = wiper_reg + 6'h01;
      else if (step && !link_bit && wiper_reg != pot_pkg::WIPER_MIN)
         wiper_next = wiper_reg - 6'h01;
      else if (settle_done)
         wiper_next = settle_val_reg;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_reg   <= pot_pkg::ST_IDLE;
         wiper_reg   <= pot_pkg::WIPER_RESET;
         shreg_reg   <= 8'h00;
         cnt_reg     <= 5'h00;
         cs_prev_reg <= 1'b1;
         tgl_d1_reg  <= 1'b0;
         tgl_d2_reg  <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         wiper_reg   <= wiper_next;
         cs_prev_reg <= cs_n_s;
         tgl_d1_reg  <= tgl_s;
         tgl_d2_reg  <= tgl_d1_reg;
         if (cs_n_s)
            cnt_reg <= 5'h00;
         else if (bit_ev)
         begin
            shreg_reg <= shreg_next;
            cnt_reg   <= cnt_next;
         end
      end
   end

   // Command latch and read data preparation ahead of the data byte
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         op_reg      <= 4'h0;
         ptr_reg     <= 2'h0;
         rd_byte_reg <= 8'h00;
         rd_en_reg   <= 1'b0;
      end
      else if (cs_n_s)
         rd_en_reg <= 1'b0;
      else if (at_ptr && op_valid)
      begin
         op_reg      <= op_in;
         ptr_reg     <= ptr_in;
         rd_byte_reg <= rd_value;
         rd_en_reg   <= read_op;
      end
   end

   // Pending save, taken only on chip select rise
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pend_reg      <= 1'b0;
         pend_ptr_reg  <= 2'h0;
         pend_data_reg <= 6'h00;
      end
      else if (cs_rise)
         pend_reg <= 1'b0;
      else if (at_instr && op_reg == pot_pkg::OP_TO_SET)
      begin
         pend_reg      <= 1'b1;
         pend_ptr_reg  <= ptr_reg;
         pend_data_reg <= wiper_reg;
      end
      else if (at_data && op_reg == pot_pkg::OP_WR_SET)
      begin
         pend_reg      <= 1'b1;
         pend_ptr_reg  <= ptr_reg;
         pend_data_reg <= shreg_next[5:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         busy_reg     <= 1'b0;
         busy_cnt_reg <= 24'h000000;
         for (int i = 0; i < pot_pkg::SET_COUNT; i++)
            set_reg[i] <= pot_pkg::SET_RESET;
      end
      else if (nv_start)
      begin
         set_reg[pend_ptr_reg] <= pend_data_reg;
         busy_reg              <= 1'b1;
         busy_cnt_reg          <= NV_LOAD;
      end
      else if (busy_reg)
      begin
         busy_cnt_reg <= busy_cnt_reg - 24'h000001;
         if (busy_cnt_reg == 24'h000001)
            busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         settle_cnt_reg <= 8'h00;
         settle_val_reg <= 6'h00;
      end
      else if (at_instr && op_reg == pot_pkg::OP_TO_WIPER)
      begin
         settle_cnt_reg <= SETTLE_LOAD;
         settle_val_reg <= set_reg[ptr_reg];
      end
      else if (settle_cnt_reg != 8'h00)
         settle_cnt_reg <= settle_cnt_reg - 8'h01;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         wiper_position  <= pot_pkg::WIPER_RESET;
         write_busy_flag <= 1'b0;
      end
      else
      begin
         wiper_position  <= wiper_next;
         write_busy_flag <= busy_reg;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_to_wiper;
      at_instr && op_reg == pot_pkg::OP_TO_WIPER;
   endsequence

   sequence s_settle_due;
      settle_done && !step
      && !(at_data && op_reg == pot_pkg::OP_WR_WIPER);
   endsequence

   AST_ID_MISMATCH: assert property (at_id && !id_match
      |=> state_reg == pot_pkg::ST_IGNORE)
      else $error("Frame not ignored after address mismatch");
   AST_BAD_OPCODE: assert property (at_ptr && !op_valid
      |=> state_reg == pot_pkg::ST_IGNORE [*2])
      else $error("Undefined opcode not ignored");
   AST_SETTLE_TIME: assert property (s_to_wiper
      |-> ##SETTLE_C settle_done)
      else $error("Settle delay length wrong");
   AST_SETTLE: assert property (s_settle_due
      |=> wiper_reg == $past(settle_val_reg))
      else $error("Transferred wiper value not applied after settle");
   AST_NO_EARLY_WIPER: assert property (s_to_wiper
      |=> settle_cnt_reg == SETTLE_LOAD && $stable(wiper_reg) || bit_ev)
      else $error("Wiper moved before settle delay");
   AST_SAVE_ON_CS_RISE: assert property ($rose(busy_reg)
      |-> $past(cs_rise) && $past(pend_reg))
      else $error("Save started without chip select rise");
   AST_WP_BLOCKS: assert property ($rose(busy_reg) |-> $past(wp_n_s))
      else $error("Save started while write protected");
   AST_INC: assert property (step && link_bit
      && wiper_reg != pot_pkg::WIPER_MAX
      |=> wiper_reg == $past(wiper_reg) + 6'h01)
      else $error("Increment did not step up");
   AST_DEC: assert property (step && !link_bit
      && wiper_reg != pot_pkg::WIPER_MIN
      |=> wiper_reg == $past(wiper_reg) - 6'h01)
      else $error("Decrement did not step down");
   AST_SATURATE: assert property (step && link_bit
      && wiper_reg == pot_pkg::WIPER_MAX |=> wiper_reg == pot_pkg::WIPER_MAX)
      else $error("Wiper wrapped at top");
   AST_RD_WIPER: assert property (at_ptr && op_in == pot_pkg::OP_RD_WIPER
      && ptr_in == 2'h0 |=> rd_en_reg && rd_byte_reg == {2'h0,
      $past(wiper_reg)})
      else $error("Wiper read data wrong");
   AST_WR_WIPER: assert property (at_data
      && op_reg == pot_pkg::OP_WR_WIPER
      |=> wiper_reg == $past(shreg_next[5:0]) ##1 wiper_position
      == $past(wiper_reg))
      else $error("Wiper write not applied");
   AST_BUSY_FLAG: assert property (nv_start |=> busy_reg ##1
      write_busy_flag)
      else $error("Busy flag not raised by save");

endmodule : pot_cmd_decoder

`default_nettype wire

//--- rtl/pot_pkg.sv
/*
 Shared constants of the potentiometer command decoder: serial framing
 bit counts, opcodes, wiper limits, reset values, timing and states.
 Assumes a 50 MHz core clock; all users write pot_pkg::name.
*/

`default_nettype none

package pot_pkg;

   localparam int         WIPER_W       = 6;
   localparam int         SET_COUNT     = 4;
   localparam int         BYTE_W        = 8;

   localparam logic [4:0] BITS_ID       = 5'h08;
   localparam logic [4:0] BITS_PTR      = 5'h0E;
   localparam logic [4:0] BITS_INSTR    = 5'h10;
   localparam logic [4:0] BITS_DATA     = 5'h18;
   localparam logic [4:0] BITS_SAT      = 5'h1F;

   localparam logic [3:0] OP_RD_WIPER   = 4'h9;
   localparam logic [3:0] OP_WR_WIPER   = 4'hA;
   localparam logic [3:0] OP_RD_SET     = 4'hB;
   localparam logic [3:0] OP_WR_SET     = 4'hC;
   localparam logic [3:0] OP_TO_WIPER   = 4'hD;
   localparam logic [3:0] OP_TO_SET     = 4'hE;
   localparam logic [3:0] OP_INCDEC     = 4'h2;
   localparam logic [3:0] OP_STATUS     = 4'h5;

   localparam logic [5:0] WIPER_MAX     = 6'h3F;
   localparam logic [5:0] WIPER_MIN     = 6'h00;
   localparam logic [5:0] WIPER_RESET   = 6'h00;
   localparam logic [5:0] SET_RESET     = 6'h00;

   localparam int         CLK_PERIOD_NS   = 20;
   localparam int         NV_WRITE_MS     = 10;
   localparam int         NV_WRITE_CYCLES =
      NV_WRITE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int         WIPER_SETTLE_NS = 1000;
   localparam int         WIPER_SETTLE_CYCLES =
      (WIPER_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0]
   {
      ST_IDLE   = 3'h0,
      ST_ID     = 3'h1,
      ST_INSTR  = 3'h3,
      ST_DATA   = 3'h2,
      ST_INCDEC = 3'h6,
      ST_IGNORE = 3'h7
   } cmd_state_t;

endpackage : pot_pkg

`default_nettype wire

//--- rtl/level_sync.sv
/*
 Two-flop synchroniser for a group of independent levels.
 Assumes each bit is a slow level or a toggle held long enough to be seen.
*/
`default_nettype none

module level_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta_reg <= INIT;
         q        <= INIT;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : level_sync

`default_nettype wire

//--- rtl/pot_link.sv
/*
 Serial clock side of the decoder: samples the input bit on each rising
 edge and reports it by toggle, and drives read data on falling edges.
 Assumes chip select high clears this domain; the core keeps read data
 and its enable steady while they are shifted out.
*/
`default_nettype none

module pot_link (
   // Serial pins
   input  wire logic       sck_clk,
   input  wire logic       cs_n,
   input  wire logic       si,
   output var  logic       so_out,
   output var  logic       so_oe,
   // From the core domain, quasi-static
   input  wire logic [7:0] rd_byte,
   input  wire logic       rd_en,
   // To the core domain
   output var  logic       bit_hold,
   output var  logic       bit_tgl
);

   logic [4:0] edge_cnt_reg;
   logic       in_read;

   assign in_read = rd_en && (edge_cnt_reg >= pot_pkg::BITS_INSTR)
                    && (edge_cnt_reg < pot_pkg::BITS_DATA);

   always_ff @(posedge sck_clk or posedge cs_n)
   begin
      if (cs_n)
      begin
         bit_hold     <= 1'b0;
         bit_tgl      <= 1'b0;
         edge_cnt_reg <= 5'h00;
      end
      else
      begin
         bit_hold <= si;
         bit_tgl  <= ~bit_tgl;
         if (edge_cnt_reg != pot_pkg::BITS_SAT)
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
      end
   end

   // MSB first on the falling edge that follows the 16th rising edge
   always_ff @(negedge sck_clk or posedge cs_n)
   begin
      if (cs_n)
      begin
         so_out <= 1'b0;
         so_oe  <= 1'b0;
      end
      else
      begin
         so_oe  <= in_read;
         so_out <= in_read ? rd_byte[~edge_cnt_reg[2:0]] : 1'b0;
      end
   end

endmodule : pot_link

`default_nettype wire

//--- sim/host_link_model.sv
/*
 Host side of the serial link: frames a command with chip select and a
 serial clock that runs only inside the frame, and collects the data byte.
 Assumes it is the only master and that callers wait out busy themselves.
*/
`default_nettype none

module host_link_model (
   // Serial pins
   output var  logic sck_clk,
   output var  logic cs_n,
   output var  logic si,
   input  wire logic so_out,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   // Released out pin floats, so a read without drive shows up
   wire logic so_line;
   assign so_line = so_oe ? so_out : 1'bz;

   initial
   begin
      sck_clk = 1'b0;
      cs_n    = 1'b1;
      si      = 1'b0;
   end

   // Bits past the third byte repeat the last data bit
   task automatic xfer(input logic [23:0] d, input int nbits,
                       output logic [7:0] rd);
      int i;
      rd   = 8'h00;
      cs_n = 1'b0;
      #70;
      for (i = 0; i < nbits; i++)
      begin
         si = d[23 - (i < 24 ? i : 23)];
         #32 sck_clk = 1'b1;
         if (i >= 16 && i < 24)
            rd = {rd[6:0], so_line};
         #32 sck_clk = 1'b0;
      end
      #32 cs_n = 1'b1;
      si = ~si;
      #200;
   endtask : xfer

endmodule : host_link_model

`default_nettype wire

//--- sim/testbench.sv
/*
 Self-checking bench of the potentiometer command decoder: runs every
 command through the host model and checks wiper, busy and read data.
 Assumes a shortened nonvolatile write time set through the parameter.
*/
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int         NV_CYC  = 200;
   localparam logic [3:0] TYPE_ID = 4'h9; // Arbitrary value
   localparam logic [7:0] ID_BYTE = {TYPE_ID, 3'b110, 1'b1};

   logic       core_clk;
   logic       sys_rst;
   logic       sck_clk;
   logic       cs_n;
   logic       si;
   logic       so_out;
   logic       so_oe;
   logic       address_select_pin;
   logic       wp_n;
   logic [5:0] wiper_position;
   logic       write_busy_flag;
   logic [7:0] rd;
   logic [7:0] id_now;
   int         mismatches;
   int         tests_run;
   int         cycles;

   pot_cmd_decoder #(
      .DEVICE_TYPE_ID  (TYPE_ID),
      .NV_WRITE_CYCLES (NV_CYC)
   ) pot_cmd_decoder_i (
      .core_clk           (core_clk),
      .sys_rst            (sys_rst),
      .sck_clk            (sck_clk),
      .cs_n               (cs_n),
      .si                 (si),
      .so_out             (so_out),
      .so_oe              (so_oe),
      .address_select_pin (address_select_pin),
      .wp_n               (wp_n),
      .wiper_position     (wiper_position),
      .write_busy_flag    (write_busy_flag)
   );

   host_link_model host_link_model_i (
      .sck_clk (sck_clk),
      .cs_n    (cs_n),
      .si      (si),
      .so_out  (so_out),
      .so_oe   (so_oe)
   );

   always #10 core_clk = ~core_clk;

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         wrap_up();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask : tick

   task automatic frame(input logic [7:0] ins, input logic [7:0] data,
                        input int nbits);
      host_link_model_i.xfer({id_now, ins, data}, nbits, rd);
      tick(1);
   endtask : frame

   task automatic wait_idle;
      int k;
      for (k = 0; k < 230 && write_busy_flag !== 1'b0; k++)
         tick(1);
      check({7'h00, write_busy_flag}, 8'h00);
   endtask : wait_idle

   task automatic read_set(input int p, input logic [7:0] exp);
      frame({pot_pkg::OP_RD_SET, p[1:0], 2'b00}, 8'h00, 24);
      check(rd, exp);
   endtask : read_set

   task automatic t_reset;
      int p;
      check({2'b00, wiper_position}, 8'h00);
      frame({pot_pkg::OP_RD_WIPER, 4'h0}, 8'h00, 24);
      check(rd, 8'h00);
      frame({pot_pkg::OP_STATUS, 4'h1}, 8'h00, 24);
      check(rd, 8'h00);
      check({7'h00, so_oe}, 8'h00);
      for (p = 0; p < 4; p++)
         read_set(p, 8'h00);
   endtask : t_reset

   task automatic t_wiper;
      frame({pot_pkg::OP_WR_WIPER, 4'h0}, 8'h2A, 24);
      check({2'b00, wiper_position}, 8'h2A);
      frame({pot_pkg::OP_RD_WIPER, 4'h0}, 8'h00, 24);
      check(rd, 8'h2A);
   endtask : t_wiper

   task automatic t_settings;
      int p;
      for (p = 0; p < 4; p++)
      begin
         frame({pot_pkg::OP_WR_SET, p[1:0], 2'b00}, 8'(5 + 17 * p), 24);
         check({7'h00, write_busy_flag}, 8'h01);
         frame({pot_pkg::OP_STATUS, 4'h1}, 8'h00, 24);
         check(rd, 8'h01);
         wait_idle();
      end
      for (p = 0; p < 4; p++)
         read_set(p, 8'(5 + 17 * p));
   endtask : t_settings

   task automatic t_protect;
      wp_n = 1'b0;
      tick(4);
      frame({pot_pkg::OP_WR_SET, 4'h0}, 8'h3C, 24);
      check({7'h00, write_busy_flag}, 8'h00);
      read_set(0, 8'h05);
      frame({pot_pkg::OP_WR_WIPER, 4'h0}, 8'h30, 24);
      check({2'b00, wiper_position}, 8'h30);
      wp_n = 1'b1;
      tick(4);
   endtask : t_protect

   task automatic t_transfer;
      frame({pot_pkg::OP_TO_WIPER, 2'd2, 2'b00}, 8'h00, 16);
      tick(30);
      check({2'b00, wiper_position}, 8'h30);
      tick(25);
      check({2'b00, wiper_position}, 8'h27);
      frame({pot_pkg::OP_TO_SET, 2'd3, 2'b00}, 8'h00, 16);
      wait_idle();
      read_set(3, 8'h27);
   endtask : t_transfer

   task automatic t_incdec;
      frame({pot_pkg::OP_INCDEC, 4'h0}, 8'hFF, 86);
      check({2'b00, wiper_position}, 8'h3F);
      frame({pot_pkg::OP_INCDEC, 4'h0}, 8'h00, 86);
      check({2'b00, wiper_position}, 8'h00);
      frame({pot_pkg::OP_INCDEC, 4'h0}, 8'hF4, 24);
      check({2'b00, wiper_position}, 8'h02);
   endtask : t_incdec

   task automatic t_refuse;
      address_select_pin = 1'b0;
      tick(4);
      frame({pot_pkg::OP_WR_WIPER, 4'h0}, 8'h11, 24);
      check({2'b00, wiper_position}, 8'h02);
      frame({pot_pkg::OP_RD_WIPER, 4'h0}, 8'h00, 24);
      check(rd, 8'hZZ);
      address_select_pin = 1'b1;
      id_now = {4'h3, 4'hD};
      tick(4);
      frame({pot_pkg::OP_WR_WIPER, 4'h0}, 8'h11, 24);
      check({2'b00, wiper_position}, 8'h02);
      id_now = ID_BYTE;
      frame(8'hF0, 8'h3F, 24);
      check({2'b00, wiper_position}, 8'h02);
      frame({pot_pkg::OP_WR_WIPER, 4'h0}, 8'h11, 24);
      check({2'b00, wiper_position}, 8'h11);
   endtask : t_refuse

   initial
   begin
      core_clk           = 1'b0;
      sys_rst            = 1'b1;
      address_select_pin = 1'b1;
      wp_n               = 1'b1;
      id_now             = ID_BYTE;
      mismatches         = 0;
      tests_run          = 0;
      cycles             = 0;
      repeat (12) @(posedge core_clk);
      #2 sys_rst = 1'b0;
      tick(4);
      t_reset();
      t_wiper();
      t_settings();
      t_protect();
      t_transfer();
      t_incdec();
      t_refuse();
      wrap_up();
   end

endmodule : testbench

`default_nettype wire
